// file: dv/bdr_host_model.sv
// Host reader model: starts a read-out and takes the output bytes one at a time.
// Assumes the formatter shows each byte until it is taken with rdNext.
`timescale 1ns/10ps
module bdr_host_model
(
   // Clock
   input  wire logic       clk,
   // Read-out handshake
   output logic            rdStart,
   output logic            rdNext,
   input  wire logic       rdValid,
   input  wire logic [7:0] rdData
);
   logic [7:0] got [1:15];

   initial
   begin
      rdStart = 1'b0;
      rdNext  = 1'b0;
   end

   // A slow host lets gap extra cycles pass before taking each byte.
   task automatic read_seq(input int n, input int gap);
      int w;
      @(posedge clk);
      rdStart <= 1'b1;
      @(posedge clk);
      rdStart <= 1'b0;
      #1;
      for (int i = 1; i <= n; i++)
      begin
         w = 0;
         while (rdValid !== 1'b1 && w < 40)
         begin
            @(posedge clk);
            #1;
            w++;
         end
         // A byte that never showed is kept as unknown so that its compare fails.
         got[i] = (rdValid === 1'b1) ? rdData : 8'hXX;
         repeat (gap) @(posedge clk);
         @(posedge clk);
         rdNext <= 1'b1;
         @(posedge clk);
         rdNext <= 1'b0;
         #1;
      end
   endtask
endmodule // bdr_host_model

// file: dv/tb_bdr_formatter.sv
// Testbench of the readout formatter: commands, received bytes and read-outs.
// Assumes the host model drives the read handshake and keeps the bytes it took.
`timescale 1ns/10ps
`include "bdr_defs.svh"
module tb_bdr_formatter;
   import bdr_pkg::*;
   logic             clk      = 1'b0;
   logic             arst_n   = 1'b0;
   logic             cmdValid = 1'b0;
   logic [7:0]       cmdId    = 8'h00;
   logic [7:0]       cmdData  = 8'h00;
   logic             rxValid  = 1'b0;
   logic [5:0]       rxIndex  = 6'h00;
   logic [7:0]       rxData   = 8'h00;
   logic             rxErr    = 1'b0;
   logic             rdStart;
   logic             rdNext;
   logic             rdValid;
   logic [7:0]       rdData;
   bdr_mode_t        cfgMode;
   logic             blockErrorMode;
   int               numErrors = 0;
   int               numChecks = 0;
   int               cycles    = 0;
   int               nb;
   logic [5:0]       base [8] = '{6'h26, 6'h16, 6'h1E, 6'h0E, 6'h1A, 6'h24, 6'h1A, 6'h24};

   always #25 clk = ~clk;

   bdr_formatter dut (.clk(clk), .arst_n(arst_n), .cmdValid(cmdValid), .cmdId(cmdId), .cmdData(cmdData),
      .rxValid(rxValid), .rxIndex(rxIndex), .rxData(rxData), .rxErr(rxErr), .rdStart(rdStart),
      .rdNext(rdNext), .rdValid(rdValid), .rdData(rdData), .cfgMode(cfgMode),
      .blockErrorMode(blockErrorMode));

   bdr_host_model host (.clk(clk), .rdStart(rdStart), .rdNext(rdNext), .rdValid(rdValid), .rdData(rdData));

   function automatic logic [7:0] val(input logic [5:0] i);
      return {i, 2'b10} ^ 8'h5A;
   endfunction

   // Data bytes of header and status modes carry seven bits and a constant one.
   function automatic logic [7:0] rev7(input logic [7:0] d);
      return {d[0], d[1], d[2], d[3], d[4], d[5], d[6], 1'b1};
   endfunction

   function automatic logic [7:0] rev8(input logic [7:0] d);
      return {<<{d}};
   endfunction

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      numChecks++;
      if (got !== exp)
      begin
         numErrors++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic cmd(input logic [7:0] id, input logic [7:0] d);
      @(posedge clk);
      cmdValid <= 1'b1;
      cmdId    <= id;
      cmdData  <= d;
      @(posedge clk);
      cmdValid <= 1'b0;
   endtask

   task automatic rx(input logic [5:0] i, input logic [7:0] d, input logic e);
      @(posedge clk);
      rxValid <= 1'b1;
      rxIndex <= i;
      rxData  <= d;
      rxErr   <= e;
      @(posedge clk);
      rxValid <= 1'b0;
   endtask

   task automatic chk_idle();
      chk("rdValid", 8'h00, {7'h00, rdValid});
      chk("rdData", 8'hFF, rdData);
      chk("cfgMode", 8'h00, {4'h0, cfgMode});
      chk("blockErrorMode", 8'h00, {7'h00, blockErrorMode});
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", numChecks, numErrors);
      if (numErrors == 0 && numChecks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // A hang shows up as a mismatch rather than a silent stall.
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         numErrors++;
         results();
      end
   end

   initial
   begin
      repeat (10) @(posedge clk);
      #1;
      chk_idle();
      @(posedge clk);
      arst_n <= 1'b1;
      $display("test reset done");
      // Each window gets one checked byte with an error, which must be held.
      for (int m = 0; m < 8; m++)
      begin
         nb = (m < 4) ? 8 : 10;
         cmd(`BDR_CMD_MODE, 8'h04 + 8'(m));
         for (int k = 0; k < nb; k++)
            rx(6'(base[m] + k), val(6'(base[m] + k)), 1'b0);
         rx(6'(base[m] + 7), 8'h00, 1'b1);
         host.read_seq(nb + 3, m % 3);
         for (int k = 0; k < nb; k++)
            chk("data", rev7(val(6'(base[m] + k))), host.got[k + 1]);
         chk("flags1", 8'h01, host.got[nb + 1]);
         chk("flags2", (m < 4) ? 8'hFF : 8'h00, host.got[nb + 2]);
         chk("spare", 8'hFF, host.got[nb + 3]);
      end
      $display("test windows done");
      cmd(`BDR_CMD_MODE, 8'h05);
      cmd(`BDR_CMD_CHECK_SEL, 8'h01);
      rx(6'h1D, 8'h00, 1'b1);
      host.read_seq(9, 0);
      chk("parityOff", 8'h01, host.got[8]);
      chk("flags", 8'h01, host.got[9]);
      $display("test parity done");
      cmd(`BDR_CMD_MODE, 8'h01);
      cmd(`BDR_CMD_CHECK_SEL, 8'h00);
      for (int i = 20; i <= 22; i++)
         rx(6'(i), val(6'(i)), 1'b0);
      cmd(`BDR_CMD_CHECK_SEL, 8'h87);
      for (int i = 20; i <= 22; i++)
         rx(6'(i), 8'h00, 1'b1);
      host.read_seq(10, 1);
      chk("pdc20", rev8(val(6'h14)), host.got[6]);
      chk("pdc21", rev8(val(6'h15)), host.got[7]);
      chk("pdc22", rev8(val(6'h16)), host.got[10]);
      cmd(`BDR_CMD_CHECK_SEL, 8'h07);
      for (int i = 20; i <= 22; i++)
         rx(6'(i), 8'h1E, 1'b1);
      host.read_seq(10, 0);
      chk("pdc20", 8'h78, host.got[6]);
      chk("pdc21", 8'h78, host.got[7]);
      chk("pdc22", 8'h78, host.got[10]);
      $display("test pdc done");
      cmd(`BDR_CMD_MODE, 8'h09);
      cmd(`BDR_CMD_CHECK_SEL, 8'h00);
      cmd(`BDR_CMD_ERR_CTRL, 8'h04);
      @(posedge clk);
      #1;
      chk("blockErrorMode", 8'h01, {7'h00, blockErrorMode});
      chk("cfgMode", 8'h09, {4'h0, cfgMode});
      rx(6'h2C, 8'h00, 1'b1);
      host.read_seq(12, 2);
      chk("written", 8'h01, host.got[9]);
      chk("flags2", 8'h80, host.got[12]);
      $display("test block error done");
      @(posedge clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk_idle();
      @(posedge clk);
      arst_n <= 1'b1;
      rx(6'h05, val(6'h05), 1'b0);
      host.read_seq(6, 0);
      chk("vps5", rev8(val(6'h05)), host.got[5]);
      cmd(`BDR_CMD_MODE, 8'h01);
      rx(6'h16, 8'h55, 1'b1);
      host.read_seq(10, 0);
      chk("held22", 8'h78, host.got[10]);
      cmd(`BDR_CMD_MODE, 8'h02);
      host.read_seq(10, 0);
      chk("auto22", 8'h78, host.got[10]);
      $display("test second reset done");
      results();
   end
endmodule // tb_bdr_formatter

// file: hdl/bdr_formatter.sv
// Broadcast data readout formatter: per-byte check settings, receive store writes and
// sequential output byte formatting for the serial read-out.
// Assumes received bytes arrive already decoded with an error flag, and that the
// serial slave raises rdStart at the start of a read and rdNext after each byte.
//
// Function
// RQ1 - Bit 2 set off checks byte 22; clear holds byte 22 on error.
// RQ2 - Bit 1 likewise governs byte 21: clear holds on error, set writes.
// RQ3 - Bit 0 governs byte 20, or the parity byte per header/status mode.
// RQ4 - Reset pin clears every setting, all check-off bits included, to zero.
// RQ5 - Output bytes are delivered in sequence starting at output byte 1.
// RQ6 - Output bits without data or flag read as one; the code reads the spare bits of status byte 12 as zero.
// RQ7 - Header modes 1/3 deliver bytes 38-45 or 30-37, bits reversed, bit 0 one.
// RQ8 - Header modes 2/4 deliver bytes 22-29 or 14-21, reversed likewise.
// RQ9 - Header output byte 9 holds eight error flags, first source at bit 7.
// RQ10 - Status modes 1/3 deliver bytes 26-35 reversed onto bits 7 to 1.
// RQ11 - Status modes 2/4 deliver bytes 36-45 reversed onto bits 7 to 1.
// RQ12 - Status bytes 11 and 12 hold ten error flags; spare bits of 12 zero.
// RQ13 - Block error mode 0 holds checked bytes with errors; mode 1 writes all.
// RQ14 - PDC and VPS bytes are fully bit-reversed, source bit 0 to bit 7.
`timescale 1ns/10ps
`include "bdr_defs.svh"
module bdr_formatter
(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              arst_n,
   // Serial command bytes
   input  wire logic              cmdValid,
   input  wire logic [7:0]        cmdId,
   input  wire logic [7:0]        cmdData,
   // Received broadcast bytes
   input  wire logic              rxValid,
   input  wire logic [5:0]        rxIndex,
   input  wire logic [7:0]        rxData,
   input  wire logic              rxErr,
   // Read-out
   input  wire logic              rdStart,
   input  wire logic              rdNext,
   output logic                   rdValid,
   output logic [7:0]             rdData,
   // Settings seen by the rest of the device
   output bdr_pkg::bdr_mode_t     cfgMode,
   output logic                   blockErrorMode
);
   import bdr_pkg::*;

   logic [2:0]   pdcHammingCheckSelectB_r;
   logic         blockErrorMode_r;
   bdr_mode_t    mode_r;
   logic [63:0]  errFlag_r;
   bdr_state_t   state_r;
   logic [3:0]   outIdx_r;
   logic [7:0]   rdData_r;
   bdr_desc_t    desc;
   logic [7:0]   errWin;
   logic         writeOk;
   logic [7:0]   revData;

   bdr_store_if  st ();

   bdr_rx_store u_store
   (
      .clk    (clk),
      .arst_n (arst_n),
      .st     (st.mem)
   );

   function automatic logic isHdr(input bdr_mode_t m);
      return (m >= `BDR_MODE_HDR1) && (m <= `BDR_MODE_HDR4);
   endfunction

   function automatic logic isSta(input bdr_mode_t m);
      return (m >= `BDR_MODE_STA1) && (m <= `BDR_MODE_STA4);
   endfunction

   function automatic logic [7:0] rev8(input logic [7:0] d);
      logic [7:0] r;
      r = 8'h00;
      for (int i = 0; i < 8; i++)
      begin
         r[7 - i] = d[i];
      end
      return r;
   endfunction

   // Returns one when checking is turned off for received byte idx in mode m.
   function automatic logic checkOff(input bdr_mode_t m, input bdr_src_t idx, input logic [2:0] sel);
      logic off;
      off = 1'b0;
      unique case (m)
         `BDR_MODE_PDC, `BDR_MODE_AUTO:
            off = (idx == `BDR_PDC_BYTE20 && sel[`BDR_BIT_OFF20]) || (idx == `BDR_PDC_BYTE21 && sel[`BDR_BIT_OFF21])
               || (idx == `BDR_PDC_BYTE22 && sel[`BDR_BIT_OFF22]);
         `BDR_MODE_HDR1: off = (idx == `BDR_PAR_HDR1) && sel[`BDR_BIT_OFF20];
         `BDR_MODE_HDR2: off = (idx == `BDR_PAR_HDR2) && sel[`BDR_BIT_OFF20];
         `BDR_MODE_HDR3: off = (idx == `BDR_PAR_HDR3) && sel[`BDR_BIT_OFF20];
         `BDR_MODE_HDR4: off = (idx == `BDR_PAR_HDR4) && sel[`BDR_BIT_OFF20];
         `BDR_MODE_STA1, `BDR_MODE_STA3:
            off = (idx == `BDR_PAR_STA13_0 && sel[`BDR_BIT_OFF20]) || (idx == `BDR_PAR_STA13_1 && sel[`BDR_BIT_OFF21])
               || (idx == `BDR_PAR_STA13_2 && sel[`BDR_BIT_OFF22]);
         `BDR_MODE_STA2, `BDR_MODE_STA4:
            off = (idx == `BDR_PAR_STA24_0 && sel[`BDR_BIT_OFF20]) || (idx == `BDR_PAR_STA24_1 && sel[`BDR_BIT_OFF21])
               || (idx == `BDR_PAR_STA24_2 && sel[`BDR_BIT_OFF22]);
         default: off = 1'b0;
      endcase
      return off;
   endfunction

   // Maps an output byte number to its kind and first source byte.
   function automatic bdr_desc_t outDesc(input bdr_mode_t m, input logic [3:0] k);
      bdr_desc_t d;
      bdr_src_t  base;
      d    = '{kind: K_ONES, src: 6'h00};
      base = 6'h00;
      unique case (m)
         `BDR_MODE_HDR1: base = `BDR_BASE_HDR1;
         `BDR_MODE_HDR2: base = `BDR_BASE_HDR2;
         `BDR_MODE_HDR3: base = `BDR_BASE_HDR3;
         `BDR_MODE_HDR4: base = `BDR_BASE_HDR4;
         `BDR_MODE_STA1, `BDR_MODE_STA3: base = `BDR_BASE_STA13;
         `BDR_MODE_STA2, `BDR_MODE_STA4: base = `BDR_BASE_STA24;
         default: base = 6'h00;
      endcase
      if (isHdr(m))
      begin
         // RQ7 RQ8 header byte window
         if (k >= 4'h1 && k <= 4'h8)
            d = '{kind: K_REV7, src: base + {2'h0, k} - 6'h01};
         // RQ9 header error byte
         else if (k == `BDR_HDR_ERR_BYTE)
            d = '{kind: K_ERR8, src: base};
      end
      else if (isSta(m))
      begin
         // RQ10 RQ11 status byte window
         if (k >= 4'h1 && k <= 4'hA)
            d = '{kind: K_REV7, src: base + {2'h0, k} - 6'h01};
         // RQ12 status error bytes
         else if (k == `BDR_STA_ERR1_BYTE)
            d = '{kind: K_ERR8, src: base};
         else if (k == `BDR_STA_ERR2_BYTE)
            d = '{kind: K_ERR2, src: base + 6'h08};
      end
      else if (m == `BDR_MODE_PDC || m == `BDR_MODE_AUTO)
      begin
         // RQ14 full reversal for PDC
         if (k >= 4'h1 && k <= 4'h7)
            d = '{kind: K_REV8, src: 6'h0E + {2'h0, k}};
         else if (k == 4'h8)
            d = '{kind: K_REV8, src: `BDR_PDC_BYTE8_SRC};
         else if (k == 4'h9)
            d = '{kind: K_REV8, src: `BDR_PDC_BYTE9_SRC};
         else if (k >= 4'hA && k <= 4'hD)
            d = '{kind: K_REV8, src: 6'h0C + {2'h0, k}};
      end
      else if (m == `BDR_MODE_VPS)
      begin
         // RQ14 full reversal for VPS
         if (k >= 4'h1 && k <= 4'h4)
            d = '{kind: K_REV8, src: 6'h0A + {2'h0, k}};
         else if (k == 4'h5)
            d = '{kind: K_REV8, src: `BDR_VPS_BYTE5_SRC};
         else if (k == 4'h6)
            d = '{kind: K_REV8, src: `BDR_VPS_BYTE6_SRC};
      end
      return d;
   endfunction

   // RQ4 settings cleared by reset
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pdcHammingCheckSelectB_r <= `BDR_CHECK_SEL_RST;
         blockErrorMode_r         <= `BDR_BLK_ERR_RST;
         mode_r                   <= `BDR_MODE_RST;
      end
      else if (cmdValid && !cmdData[`BDR_CMD_SECOND_BIT])
      begin
         if (cmdId == `BDR_CMD_CHECK_SEL)
            pdcHammingCheckSelectB_r <= cmdData[`BDR_CHECK_SEL_W-1:0];
         if (cmdId == `BDR_CMD_ERR_CTRL)
            blockErrorMode_r <= cmdData[`BDR_BIT_BLK_ERR];
         if (cmdId == `BDR_CMD_MODE)
            mode_r <= cmdData[3:0];
      end
   end

   // RQ1 RQ2 RQ3 RQ13 write or hold decision
   assign writeOk = blockErrorMode_r || !rxErr || checkOff(mode_r, rxIndex, pdcHammingCheckSelectB_r);

   assign st.we    = rxValid && writeOk;
   assign st.waddr = rxIndex;
   assign st.wdata = rxData;

   // Error flags follow every received byte, whether or not its data was kept.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         errFlag_r <= 64'h0000_0000_0000_0000;
      else if (rxValid)
         errFlag_r[rxIndex] <= rxErr;
   end

   // Read-out sequencer; the store needs one clock to answer a new address.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_r  <= S_IDLE;
         outIdx_r <= `BDR_OUT_FIRST;
      end
      else if (rdStart)
      begin
         // RQ5 sequence starts at byte 1
         state_r  <= S_FETCH;
         outIdx_r <= `BDR_OUT_FIRST;
      end
      else
      begin
         unique case (state_r)
            S_IDLE:  state_r <= S_IDLE;
            S_FETCH: state_r <= S_LOAD;
            S_LOAD:  state_r <= S_SHOW;
            S_SHOW:
               if (rdNext)
               begin
                  state_r  <= S_FETCH;
                  outIdx_r <= (outIdx_r == `BDR_OUT_LAST) ? outIdx_r : outIdx_r + 4'h1;
               end
         endcase
      end
   end

   assign desc     = outDesc(mode_r, outIdx_r);
   assign st.raddr = desc.src;
   assign revData  = rev8(st.rdata);

   always_comb
   begin
      errWin = 8'h00;
      for (int i = 0; i < 8; i++)
      begin
         errWin[7 - i] = errFlag_r[desc.src + 6'(i)];
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         rdData_r <= `BDR_OUT_RST;
      else if (state_r == S_LOAD)
      begin
         unique case (desc.kind)
            // RQ6 unassigned bits read one
            K_ONES: rdData_r <= 8'hFF;
            K_REV7: rdData_r <= {revData[7:1], 1'b1};
            K_REV8: rdData_r <= rev8(st.rdata);
            K_ERR8: rdData_r <= errWin;
            // RQ12 spare flag bits zero
            K_ERR2: rdData_r <= {errWin[7:6], 6'h00};
            default: rdData_r <= 8'hFF;
         endcase
      end
   end

   assign rdValid        = (state_r == S_SHOW);
   assign rdData         = rdData_r;
   assign cfgMode        = mode_r;
   assign blockErrorMode = blockErrorMode_r;

   reset_clears_a: assert property (@(posedge clk) disable iff (!arst_n) // RQ4
      $rose(arst_n) |-> (pdcHammingCheckSelectB_r == 3'h0) && !blockErrorMode_r && (mode_r == 4'h0))
      else $error("settings not clear after reset");

   byte22_hold_a: assert property (@(posedge clk) disable iff (!arst_n) // RQ1
      rxValid && rxErr && !blockErrorMode_r && mode_r == 4'h1 && rxIndex == 6'h16
      && !pdcHammingCheckSelectB_r[2] |-> !st.we)
      else $error("byte 22 written despite error");

   byte21_write_a: assert property (@(posedge clk) disable iff (!arst_n) // RQ2
      rxValid && mode_r == 4'h1 && rxIndex == 6'h15 && pdcHammingCheckSelectB_r[1] |-> st.we)
      else $error("byte 21 not written with check off");

   parity_hold_a: assert property (@(posedge clk) disable iff (!arst_n) // RQ3
      rxValid && rxErr && !blockErrorMode_r && mode_r == 4'h4 && rxIndex == 6'h2D
      && !pdcHammingCheckSelectB_r[0] |-> !st.we)
      else $error("header 1 parity byte written despite error");

   write_all_a: assert property (@(posedge clk) disable iff (!arst_n) // RQ13
      rxValid && blockErrorMode_r |-> st.we && st.waddr == rxIndex)
      else $error("byte dropped with block error mode 1");

   start_first_a: assert property (@(posedge clk) disable iff (!arst_n) // RQ5
      rdStart |-> ##3 rdValid && outIdx_r == 4'h1)
      else $error("read-out did not start at byte 1");

   header_bit0_a: assert property (@(posedge clk) disable iff (!arst_n) // RQ7
      state_r == S_LOAD && isHdr(mode_r) && outIdx_r >= 4'h1 && outIdx_r <= 4'h8 |=> rdData[0])
      else $error("header data byte bit 0 not one");

   status_err2_a: assert property (@(posedge clk) disable iff (!arst_n) // RQ12
      state_r == S_LOAD && isSta(mode_r) && outIdx_r == `BDR_STA_ERR2_BYTE |=> rdData[5:0] == 6'h00)
      else $error("status error byte 12 spare bits not zero");

   next_timing_a: assert property (@(posedge clk) disable iff (!arst_n) // RQ5
      rdValid && rdNext && !rdStart |=> !rdValid ##2 rdValid)
      else $error("next byte not shown three clocks after advance");

endmodule // bdr_formatter

// file: hdl/bdr_rx_store.sv
// Store of received broadcast bytes, indexed by byte number.
// Read data is registered, so it follows the read address by one clock.
`timescale 1ns/10ps
`include "bdr_defs.svh"
module bdr_rx_store
(
   // Clock and reset
   input  wire logic    clk,
   input  wire logic    arst_n,
   // Store port
   bdr_store_if.mem     st
);
   import bdr_pkg::*;

   logic [7:0] mem [0:63];

   always_ff @(posedge clk)
   begin
      if (st.we)
      begin
         mem[st.waddr] <= st.wdata;
      end
   end

   // The array itself has no reset; bytes never received read as whatever was there.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st.rdata <= `BDR_OUT_RST;
      end
      else
      begin
         st.rdata <= mem[st.raddr];
      end
   end

endmodule // bdr_rx_store

// file: include/bdr_defs.svh
// Constants of the broadcast data readout formatter: command codes, bit positions,
// mode codes, source byte numbers and reset values. Definitions only.
`ifndef BDR_DEFS_SVH
`define BDR_DEFS_SVH

// Command identification bytes (first byte of a two-byte command).
`define BDR_CMD_CHECK_SEL   8'hF9
`define BDR_CMD_ERR_CTRL    8'hF6
`define BDR_CMD_MODE        8'hF0
`define BDR_CMD_SECOND_BIT  7

// Field positions in the second command byte.
`define BDR_CHECK_SEL_W     3
`define BDR_BIT_OFF22       2
`define BDR_BIT_OFF21       1
`define BDR_BIT_OFF20       0
`define BDR_BIT_BLK_ERR     2

// Reset values of the settings.
`define BDR_CHECK_SEL_RST   3'h0
`define BDR_MODE_RST        4'h0
`define BDR_BLK_ERR_RST     1'h0
`define BDR_OUT_RST         8'hFF

// Operating mode codes.
`define BDR_MODE_VPS        4'h0
`define BDR_MODE_PDC        4'h1
`define BDR_MODE_AUTO       4'h2
`define BDR_MODE_UDT        4'h3
`define BDR_MODE_HDR1       4'h4
`define BDR_MODE_HDR2       4'h5
`define BDR_MODE_HDR3       4'h6
`define BDR_MODE_HDR4       4'h7
`define BDR_MODE_STA1       4'h8
`define BDR_MODE_STA2       4'h9
`define BDR_MODE_STA3       4'hA
`define BDR_MODE_STA4       4'hB

// First source byte of each header and status window.
`define BDR_BASE_HDR1       6'h26
`define BDR_BASE_HDR2       6'h16
`define BDR_BASE_HDR3       6'h1E
`define BDR_BASE_HDR4       6'h0E
`define BDR_BASE_STA13      6'h1A
`define BDR_BASE_STA24      6'h24

// Source bytes governed by the three check-off bits.
`define BDR_PDC_BYTE20      6'h14
`define BDR_PDC_BYTE21      6'h15
`define BDR_PDC_BYTE22      6'h16
`define BDR_PAR_HDR1        6'h2D
`define BDR_PAR_HDR2        6'h1D
`define BDR_PAR_HDR3        6'h25
`define BDR_PAR_HDR4        6'h15
`define BDR_PAR_STA13_0     6'h21
`define BDR_PAR_STA13_1     6'h22
`define BDR_PAR_STA13_2     6'h23
`define BDR_PAR_STA24_0     6'h2B
`define BDR_PAR_STA24_1     6'h2C
`define BDR_PAR_STA24_2     6'h2D

// Output byte layout.
`define BDR_OUT_FIRST       4'h1
`define BDR_OUT_LAST        4'hF
`define BDR_HDR_ERR_BYTE    4'h9
`define BDR_STA_ERR1_BYTE   4'hB
`define BDR_STA_ERR2_BYTE   4'hC
`define BDR_PDC_BYTE8_SRC   6'h0D
`define BDR_PDC_BYTE9_SRC   6'h0E
`define BDR_VPS_BYTE5_SRC   6'h05
`define BDR_VPS_BYTE6_SRC   6'h0F

`endif

// file: include/bdr_pkg.sv
// Types shared by the formatter and its receive store.
// Assumes bdr_defs.svh is on the include path.
package bdr_pkg;

   typedef logic [3:0] bdr_mode_t;
   typedef logic [5:0] bdr_src_t;

   typedef enum logic [2:0] {
      K_ONES,
      K_REV7,
      K_REV8,
      K_ERR8,
      K_ERR2
   } bdr_kind_t;

   typedef struct packed {
      bdr_kind_t kind;
      bdr_src_t  src;
   } bdr_desc_t;

   typedef enum logic [1:0] {
      S_IDLE,
      S_FETCH,
      S_LOAD,
      S_SHOW
   } bdr_state_t;

endpackage

// file: include/bdr_store_if.sv
// Carrier between the formatter and its receive store: one write port, one read port.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface bdr_store_if;
   logic       we;
   logic [5:0] waddr;
   logic [7:0] wdata;
   logic [5:0] raddr;
   logic [7:0] rdata;

   modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
   modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
